// file: core/safety_pkg.sv
package safety_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register byte offsets on the avalon slave
   localparam logic [3:0] CTRL_OFS = 4'h0;
   localparam logic [3:0] DELAY_OFS = 4'h4;
   localparam logic [3:0] STATUS_OFS = 4'h8;

   ////////////////////////////////////////////////////////////////////////////
   // control register fields
   localparam int CTRL_DUAL_BIT = 0;
   localparam int CTRL_AUTO_BIT = 1;
   localparam int CTRL_SUPP_USED_BIT = 2;
   localparam int CTRL_INIT_TEST_BIT = 3;
   localparam int CTRL_MODE_LSB = 4;
   localparam logic [31:0] CTRL_MASK = 32'h0000003F;
   localparam logic [31:0] CTRL_RESET = 32'h00000005;

   ////////////////////////////////////////////////////////////////////////////
   // status register fields
   localparam int STAT_ENABLE_BIT = 0;
   localparam int STAT_DLY_OUT_BIT = 1;
   localparam int STAT_TEST_DONE_BIT = 2;
   localparam int STAT_CHAN_OK_BIT = 3;
   localparam int STAT_SUPP_BIT = 4;
   localparam int STAT_START_BIT = 5;
   localparam int STAT_RELEASE_BIT = 6;
   localparam int STAT_CNT_LSB = 16;

   ////////////////////////////////////////////////////////////////////////////
   // delay time, counted in scan ticks
   localparam int DELAY_W = 16;
   localparam logic [31:0] DELAY_RESET = 32'h000000C8;

   ////////////////////////////////////////////////////////////////////////////
   // timing
   localparam longint CLK_PERIOD_PS = 5000;
   localparam longint SCAN_TICK_MS = 10;
   localparam int SCAN_TICK_CYCLES = int'((SCAN_TICK_MS * 1000000000 + CLK_PERIOD_PS - 1)
                                          / CLK_PERIOD_PS);

   ////////////////////////////////////////////////////////////////////////////
   // modes and states
   typedef enum logic [1:0] {DLY_DROP_OUT, DLY_PICK_UP, DLY_TIMER} delay_mode_t;
   typedef enum logic {EN_OFF, EN_ON} en_state_t;

endpackage : safety_pkg

// file: core/safety_switch_delay.sv
// Notes on behaviour
// - one or two channels feed one enable
// - edge start: enable on start trailing edge
// - auto start: enable once guard closed
// - supplementary condition optional, needed when assigned
// - no enable while an assigned supplementary condition is false
// - guard opened withdraws the enable
// - channel drop clears enable immediately, undelayed
// - optional initial test before first enable
// - drop-out: output off after delay elapsed
// - pick-up: output on after delay elapsed
// - timer: square wave, period twice delay
// - single fixed periodic timer resource only
// - unlock request releases solenoid without delay
`timescale 1ns/10ps

module safety_switch_delay
   import safety_pkg::*;
#(
   parameter int TICK_CYCLES = SCAN_TICK_CYCLES,
   parameter int DLY_W = DELAY_W
) (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // avalon-mm slave
   input wire logic [3:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   // safety switch inputs
   input wire logic chan1,
   input wire logic chan2,
   input wire logic start_btn,
   input wire logic supplementary_condition,
   // delay element and solenoid
   input wire logic delay_in,
   input wire logic unlock_req,
   // outputs
   output logic enable,
   output logic delay_out,
   output logic solenoid_release
);

   localparam int TW = $clog2(TICK_CYCLES + 1);

   if (TICK_CYCLES < 1) begin : g_chk_tick
      $error("TICK_CYCLES must be at least 1");
   end
   if (DLY_W < 1 || DLY_W > 16) begin : g_chk_dly
      $error("DLY_W must lie between 1 and 16");
   end

   ////////////////////////////////////////////////////////////////////////////
   // state

   typedef struct packed {
      logic [TW-1:0] tick_cnt;
      logic tick;
      logic ch1_s;
      logic ch2_s;
      logic start_s;
      logic start_prev;
      logic supp_s;
      logic dly_in_s;
      en_state_t en_st;
      logic enable;
      logic test_done;
      logic dly_out;
      logic [DLY_W-1:0] dly_cnt;
      logic release_q;
      logic [31:0] ctrl;
      logic [DLY_W-1:0] dly_time;
      logic waitreq;
      logic [31:0] rdata;
   } state_t;

   localparam state_t RST_STATE = '{
      ctrl: CTRL_RESET,
      dly_time: DELAY_RESET[DLY_W-1:0],
      waitreq: 1'b1,
      en_st: EN_OFF,
      default: '0
   };

   state_t r_ff;
   state_t nxt_r;

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   // true when one more tick completes the delay
   function automatic logic elapsed(input logic [DLY_W-1:0] cnt,
                                    input logic [DLY_W-1:0] lim);
      logic [DLY_W:0] nxt;
      nxt = {1'b0, cnt} + {{DLY_W{1'b0}}, 1'b1};
      return nxt >= {1'b0, lim};
   endfunction : elapsed

   function automatic logic [31:0] be_merge(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0] be);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return res;
   endfunction : be_merge

   ////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      logic dual;
      logic chan_raw;
      logic chan_ok;
      logic supp_ok;
      logic test_ok;
      logic fall;
      logic start_ok;
      logic [31:0] rd;
      logic [31:0] dly_word;
      delay_mode_t mode;

      nxt_r = r_ff;
      rd = '0;
      dly_word = '0;
      dual = r_ff.ctrl[CTRL_DUAL_BIT];
      mode = delay_mode_t'(r_ff.ctrl[CTRL_MODE_LSB +: 2]);

      // scan tick generator and input sampling
      nxt_r.tick = 1'b0;
      if (r_ff.tick_cnt == TW'(TICK_CYCLES - 1)) begin
         nxt_r.tick_cnt = '0;
         nxt_r.tick = 1'b1;
         nxt_r.ch1_s = chan1;
         nxt_r.ch2_s = chan2;
         nxt_r.start_s = start_btn;
         nxt_r.supp_s = supplementary_condition;
         nxt_r.dly_in_s = delay_in;
      end else begin
         nxt_r.tick_cnt = r_ff.tick_cnt + TW'(1);
      end

      // channel evaluation
      chan_raw = chan1 & (~dual | chan2);
      chan_ok = r_ff.ch1_s & (~dual | r_ff.ch2_s);
      supp_ok = ~r_ff.ctrl[CTRL_SUPP_USED_BIT] | r_ff.supp_s;
      test_ok = ~r_ff.ctrl[CTRL_INIT_TEST_BIT] | r_ff.test_done;
      fall = r_ff.start_prev & ~r_ff.start_s;
      start_ok = r_ff.ctrl[CTRL_AUTO_BIT] | fall;
      if (r_ff.tick) begin
         nxt_r.start_prev = r_ff.start_s;
      end

      // the initial test is passed once the guard has been seen open
      if (~chan1 & (~dual | ~chan2)) begin
         nxt_r.test_done = 1'b1;
      end

      // enable state machine
      case (r_ff.en_st)
         EN_OFF: begin
            if (r_ff.tick && chan_ok && supp_ok && test_ok && start_ok) begin
               nxt_r.en_st = EN_ON;
            end
         end
         EN_ON: begin
            if (r_ff.tick && (!supp_ok || !chan_ok)) begin
               nxt_r.en_st = EN_OFF;
            end
         end
         default: begin
            nxt_r.en_st = EN_OFF;
         end
      endcase
      // raw channel drop bypasses the scan tick and any delay
      if (!chan_raw) begin
         nxt_r.en_st = EN_OFF;
      end
      nxt_r.enable = (nxt_r.en_st == EN_ON);

      // delay element; one counter of scan ticks serves all three modes
      if (r_ff.tick) begin
         case (mode)
            DLY_DROP_OUT: begin
               if (r_ff.dly_in_s) begin
                  nxt_r.dly_out = 1'b1;
                  nxt_r.dly_cnt = '0;
               end else if (r_ff.dly_out) begin
                  if (elapsed(r_ff.dly_cnt, r_ff.dly_time)) begin
                     nxt_r.dly_out = 1'b0;
                     nxt_r.dly_cnt = '0;
                  end else begin
                     nxt_r.dly_cnt = r_ff.dly_cnt + DLY_W'(1);
                  end
               end
            end
            DLY_PICK_UP: begin
               if (!r_ff.dly_in_s) begin
                  nxt_r.dly_out = 1'b0;
                  nxt_r.dly_cnt = '0;
               end else if (!r_ff.dly_out) begin
                  if (elapsed(r_ff.dly_cnt, r_ff.dly_time)) begin
                     nxt_r.dly_out = 1'b1;
                     nxt_r.dly_cnt = '0;
                  end else begin
                     nxt_r.dly_cnt = r_ff.dly_cnt + DLY_W'(1);
                  end
               end
            end
            DLY_TIMER: begin
               if (elapsed(r_ff.dly_cnt, r_ff.dly_time)) begin
                  nxt_r.dly_out = ~r_ff.dly_out;
                  nxt_r.dly_cnt = '0;
               end else begin
                  nxt_r.dly_cnt = r_ff.dly_cnt + DLY_W'(1);
               end
            end
            default: begin
               nxt_r.dly_out = 1'b0;
               nxt_r.dly_cnt = '0;
            end
         endcase
      end

      // solenoid release follows the unlock request with no delay
      nxt_r.release_q = unlock_req;

      ////////////////////////////////////////////////////////////////////////
      // avalon slave: one wait cycle, then the access completes

      rd = '0;
      case (address)
         CTRL_OFS: begin
            rd = r_ff.ctrl;
         end
         DELAY_OFS: begin
            rd[DLY_W-1:0] = r_ff.dly_time;
         end
         STATUS_OFS: begin
            rd[STAT_ENABLE_BIT] = r_ff.enable;
            rd[STAT_DLY_OUT_BIT] = r_ff.dly_out;
            rd[STAT_TEST_DONE_BIT] = r_ff.test_done;
            rd[STAT_CHAN_OK_BIT] = chan_ok;
            rd[STAT_SUPP_BIT] = r_ff.supp_s;
            rd[STAT_START_BIT] = r_ff.start_s;
            rd[STAT_RELEASE_BIT] = r_ff.release_q;
            rd[STAT_CNT_LSB +: DLY_W] = r_ff.dly_cnt;
         end
         default: begin
            rd = '0;
         end
      endcase

      nxt_r.waitreq = ~((read | write) & r_ff.waitreq);
      nxt_r.rdata = (read & r_ff.waitreq) ? rd : '0;

      if (write && !r_ff.waitreq) begin
         case (address)
            CTRL_OFS: begin
               nxt_r.ctrl = be_merge(r_ff.ctrl, writedata, byteenable) & CTRL_MASK;
            end
            DELAY_OFS: begin
               dly_word = '0;
               dly_word[DLY_W-1:0] = r_ff.dly_time;
               dly_word = be_merge(dly_word, writedata, byteenable);
               nxt_r.dly_time = dly_word[DLY_W-1:0];
            end
            default: begin
               nxt_r.ctrl = r_ff.ctrl;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         r_ff <= RST_STATE;
      end else begin
         r_ff <= nxt_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   assign readdata = r_ff.rdata;
   assign waitrequest = r_ff.waitreq;
   assign enable = r_ff.enable;
   assign delay_out = r_ff.dly_out;
   assign solenoid_release = r_ff.release_q;

endmodule : safety_switch_delay

// file: bench/safety_switch_delay_chk.sv
`timescale 1ns/10ps
module safety_switch_delay_chk
   import safety_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // bus
   input wire logic [3:0] address,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   input wire logic waitrequest,
   // pins
   input wire logic chan1,
   input wire logic chan2,
   input wire logic start_btn,
   input wire logic supplementary_condition,
   input wire logic delay_in,
   input wire logic unlock_req,
   input wire logic enable,
   input wire logic delay_out,
   input wire logic solenoid_release
);
   // shadow of the control register
   logic [5:0] ctrl_ff;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) ctrl_ff <= CTRL_RESET[5:0];
      else if (write && !waitrequest && address == CTRL_OFS && byteenable[0])
         ctrl_ff <= writedata[5:0];
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   chk_rel_follow:
      assert property ($past(arst_n) |-> solenoid_release == $past(unlock_req))
      else $error("release not one clock after request");
   chk_chan1_drop:
      assert property (!chan1 |=> !enable) else $error("enable kept after chan1 drop");
   chk_chan2_drop:
      assert property (ctrl_ff[0] && !chan2 |=> !enable)
      else $error("enable kept after chan2 drop");
   chk_supp_gate:
      assert property ($rose(enable) && ctrl_ff[2] |-> $past(supplementary_condition, 2))
      else $error("enable without condition");
   chk_edge_start:
      assert property ($rose(enable) && !ctrl_ff[1] |-> !$past(start_btn, 2))
      else $error("edge start while button held");
   chk_reset_clear:
      assert property ($rose(arst_n) |-> !enable && !delay_out && !solenoid_release)
      else $error("outputs not clear after reset");
   chk_drop_hold:
      assert property ($fell(delay_out) && ctrl_ff[5:4] == 2'h0 |-> !$past(delay_in, 2))
      else $error("drop-out fell with input high");
   chk_pick_wait:
      assert property ($rose(delay_out) && ctrl_ff[5:4] == 2'h1 |-> $past(delay_in, 2))
      else $error("pick-up rose with input low");
endmodule : safety_switch_delay_chk

bind safety_switch_delay safety_switch_delay_chk chk_i (.clk(clk), .arst_n(arst_n),
   .address(address), .write(write), .writedata(writedata), .byteenable(byteenable),
   .waitrequest(waitrequest), .chan1(chan1), .chan2(chan2), .start_btn(start_btn),
   .supplementary_condition(supplementary_condition), .delay_in(delay_in),
   .unlock_req(unlock_req), .enable(enable), .delay_out(delay_out),
   .solenoid_release(solenoid_release));

// file: bench/guard_model.sv
`timescale 1ns/10ps
module guard_model (
   // clock
   input wire logic clk,
   // scenario controls
   input wire logic closed,
   input wire logic fault2,
   input wire logic press,
   input wire logic fb_ok,
   // contacts
   output logic chan1,
   output logic chan2,
   output logic start_btn,
   output logic supplementary_condition
);
   // second contact closes late, opens at once
   logic [2:0] lag_ff = 3'h0;
   always_ff @(posedge clk) lag_ff <= {lag_ff[1:0], closed};
   assign chan1 = closed;
   assign chan2 = closed && lag_ff[2] && !fault2;
   assign start_btn = press;
   assign supplementary_condition = fb_ok;
endmodule : guard_model

// file: bench/safety_switch_delay_tb.sv
`timescale 1ns/10ps
module safety_switch_delay_tb;
   import safety_pkg::*;
   localparam int TK = 4;
   localparam int DW = TK * 3;
   localparam logic [31:0] ST_ON = (32'h1 << STAT_ENABLE_BIT) | (32'h1 << STAT_TEST_DONE_BIT)
      | (32'h1 << STAT_CHAN_OK_BIT) | (32'h1 << STAT_SUPP_BIT);
   logic clk, arst_n, read, write, delay_in, unlock_req, closed, fault2, press, fb_ok;
   logic [3:0] address, byteenable;
   logic [31:0] writedata, readdata, rdata;
   logic waitrequest, chan1, chan2, start_btn, supplementary_condition;
   logic enable, delay_out, solenoid_release;
   int errors, compares, cnt, cyc;
   safety_switch_delay #(.TICK_CYCLES(TK)) uut (.clk(clk), .arst_n(arst_n),
      .address(address), .read(read), .write(write), .writedata(writedata),
      .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
      .chan1(chan1), .chan2(chan2), .start_btn(start_btn),
      .supplementary_condition(supplementary_condition), .delay_in(delay_in),
      .unlock_req(unlock_req), .enable(enable), .delay_out(delay_out),
      .solenoid_release(solenoid_release));
   guard_model partner (.clk(clk), .closed(closed), .fault2(fault2), .press(press),
      .fb_ok(fb_ok), .chan1(chan1), .chan2(chan2), .start_btn(start_btn),
      .supplementary_condition(supplementary_condition));
   ////////////////////////////////////////////////////////////////////////////
   task cmp(input string n, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask : cmp
   task cy(input int n);
      repeat (n) @(posedge clk);
   endtask : cy
   // one bus access; an idle edge follows so strobes are never set twice at once
   task acc(input logic w, input logic [3:0] a, input logic [31:0] d);
      address <= a;
      writedata <= d;
      byteenable <= 4'hF;
      write <= w;
      read <= !w;
      @(posedge clk);
      while (waitrequest !== 1'b0) @(posedge clk);
      rdata = readdata;
      write <= 1'b0;
      read <= 1'b0;
      @(posedge clk);
   endtask : acc
   task wt(input logic s, input logic v, input int n);
      cnt = 0;
      while ((s ? delay_out : enable) !== v && cnt < n) begin
         @(posedge clk);
         cnt++;
      end
   endtask : wt
   task close_out;
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : close_out
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         errors++;
         close_out();
      end
   end
   initial begin
      {arst_n, read, write, delay_in, unlock_req, closed, fault2, press, fb_ok} = '0;
      address = 4'h0;
      byteenable = 4'h0;
      writedata = 32'h0;
      cy(12);
      arst_n <= 1'b1;
      acc(0, CTRL_OFS, 32'h0);
      cmp("ctrl", CTRL_RESET, rdata);
      acc(0, DELAY_OFS, 32'h0);
      cmp("delay", DELAY_RESET, rdata);
      acc(0, 4'hC, 32'h0);
      cmp("unmapped", 32'h0, rdata);
      // auto start, one channel, feedback used; bits above the fields read 0
      acc(1, CTRL_OFS, 32'hFFFFFF06);
      acc(0, CTRL_OFS, 32'h0);
      cmp("ctrl_mask", 32'h6, rdata);
      closed <= 1'b1;
      cy(40);
      cmp("enable", 0, enable);
      fb_ok <= 1'b1;
      wt(0, 1, 40);
      cmp("enable", 1, enable);
      acc(0, STATUS_OFS, 32'h0);
      cmp("status", ST_ON, rdata);
      closed <= 1'b0;
      cy(3);
      cmp("enable", 0, enable);
      // edge start, two channels
      acc(1, CTRL_OFS, 32'h5);
      closed <= 1'b1;
      cy(40);
      cmp("enable", 0, enable);
      press <= 1'b1;
      cy(20);
      cmp("enable", 0, enable);
      press <= 1'b0;
      wt(0, 1, 40);
      cmp("enable", 1, enable);
      fault2 <= 1'b1;
      cy(3);
      cmp("enable", 0, enable);
      fault2 <= 1'b0;
      // delay element, three ticks
      acc(1, DELAY_OFS, 32'h3);
      delay_in <= 1'b1;
      wt(1, 1, 40);
      cmp("dly_on", 1, delay_out);
      delay_in <= 1'b0;
      wt(1, 0, 60);
      cmp("dly_hold", 1, cnt > DW - TK && cnt <= DW + 2 * TK);
      acc(1, CTRL_OFS, 32'h15);
      delay_in <= 1'b1;
      wt(1, 1, 60);
      cmp("dly_wait", 1, cnt > DW - TK && cnt <= DW + 2 * TK);
      acc(1, CTRL_OFS, 32'h25);
      wt(1, 0, 60);
      wt(1, 1, 60);
      wt(1, 0, 60);
      cmp("half_period", DW, cnt);
      // the unused mode code parks the output low
      wt(1, 1, 60);
      acc(1, CTRL_OFS, 32'h35);
      cy(8);
      cmp("dly_parked", 0, delay_out);
      unlock_req <= 1'b1;
      cy(2);
      cmp("release", 1, solenoid_release);
      unlock_req <= 1'b0;
      cy(2);
      cmp("release", 0, solenoid_release);
      // initial test needs the guard seen open after reset
      arst_n <= 1'b0;
      delay_in <= 1'b0;
      cy(12);
      arst_n <= 1'b1;
      acc(0, CTRL_OFS, 32'h0);
      cmp("ctrl", CTRL_RESET, rdata);
      acc(1, CTRL_OFS, 32'hA);
      cy(40);
      cmp("enable", 0, enable);
      closed <= 1'b0;
      cy(20);
      closed <= 1'b1;
      wt(0, 1, 60);
      cmp("enable", 1, enable);
      close_out();
   end
endmodule : safety_switch_delay_tb
